/* kitop_pkg.sv */
package kitop_pkg;

  // ==========================================================
  // Register map (byte address is four times the index)
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] IDX_PIN_LEVELS = 8'he0;
  localparam logic [7:0] IDX_IRQ_ENABLES = 8'he8;
  localparam logic [7:0] IDX_IRQ_FLAG = 8'hed;
  localparam logic [7:0] IDX_OUT_DATA = 8'hf3;
  localparam logic [7:0] IDX_FREQ_CTRL = 8'hfd;

  // ==========================================================
  // Field positions and reset values
  localparam int unsigned FLD_FLAG = 0;
  localparam int unsigned FLD_OUT_ZERO = 0;
  localparam int unsigned FLD_OUT_ONE = 1;
  localparam int unsigned FLD_RATE_LO = 0;
  localparam int unsigned FLD_RATE_HI = 1;
  localparam int unsigned FLD_TONE = 3;
  localparam logic [3:0] EN_RST = 4'h0;
  localparam logic FLAG_RST = 1'b0;
  localparam logic [1:0] OUT_RST = 2'h0;
  localparam logic [1:0] RATE_RST = 2'h0;
  localparam logic TONE_RST = 1'b0;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned FILTER_TIME_NS = 500000;
  localparam int unsigned FILTER_CYCLES = FILTER_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned PHASE_W = 7;
  localparam int unsigned SET1_F1_LOG2 = 7;
  localparam int unsigned TONE_2K_LOG2 = 4;
  localparam int unsigned TONE_4K_LOG2 = 3;

  typedef enum logic [1:0] {OUT0_PLAIN, OUT0_CLOCK, OUT0_INV_BUZZER} kitop_out0_mode_e;

  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction

  // Divisor exponent for a divisor set (1..5) and a rate code
  function automatic int unsigned rate_log2(input int unsigned set, input logic [1:0] code);
    return SET1_F1_LOG2 + 1 - set - int'(code);
  endfunction

endpackage

/* kitop_divider.sv */
`timescale 1ns/1ns
`default_nettype none
module kitop_divider
  import kitop_pkg::*;
#(
  parameter int unsigned WIDTH = PHASE_W
)
(
  input wire logic pclk,
  input wire logic presetn,
  output logic [WIDTH-1:0] phase
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } kitop_div_s;

  kitop_div_s s_q;
  kitop_div_s s_d;

  if (WIDTH < 1)
  begin : bad_width_g
    $error("kitop_divider: WIDTH must be at least 1");
  end

  // Free-running; bit k is the clock divided by 2^(k+1)
  always_comb
  begin
    s_d = s_q;
    s_d.cnt = s_q.cnt + WIDTH'(1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign phase = s_q.cnt;

endmodule
`default_nettype wire

/* kitop_in_filter.sv */
`timescale 1ns/1ns
`default_nettype none
module kitop_in_filter
  import kitop_pkg::*;
#(
  parameter int unsigned WIDTH = 4,
  parameter bit FILTER_EN = 1'b1,
  parameter int unsigned FILT_CYCLES = FILTER_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] clean
);

  localparam int unsigned CW = $clog2(FILT_CYCLES + 1);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
    logic [WIDTH-1:0] cln;
    logic [WIDTH-1:0][CW-1:0] cnt;
  } kitop_filt_s;

  kitop_filt_s s_q;
  kitop_filt_s s_d;

  if (WIDTH < 1 || FILT_CYCLES < 1)
  begin : bad_param_g
    $error("kitop_in_filter: WIDTH and FILT_CYCLES must be at least 1");
  end

  always_comb
  begin
    s_d = s_q;
    s_d.s1 = pins;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    for (int i = 0; i < WIDTH; i++)
    begin
      // A change counts only once two late stages agree
      if (s_q.s2[i] == s_q.s3[i])
        s_d.lvl[i] = s_q.s3[i];
      // Noise rejection: the level must hold for the whole window
      if (s_q.lvl[i] == s_q.cln[i])
        s_d.cnt[i] = '0;
      else if (s_q.cnt[i] == CW'(FILT_CYCLES - 1))
      begin
        s_d.cln[i] = s_q.lvl[i];
        s_d.cnt[i] = '0;
      end
      else
        s_d.cnt[i] = s_q.cnt[i] + CW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign level = s_q.lvl;
  assign clean = FILTER_EN ? s_q.cln : s_q.lvl;

endmodule
`default_nettype wire

/* kitop_port.sv */
`timescale 1ns/1ns
`default_nettype none
module kitop_port
  import kitop_pkg::*;
#(
  parameter kitop_out0_mode_e OUT0_MODE = OUT0_PLAIN,
  parameter bit OUT1_BUZZER = 1'b0,
  parameter bit INV_BY_BIT1 = 1'b0,
  parameter bit OUT0_OPEN_DRAIN = 1'b0,
  parameter bit OUT1_OPEN_DRAIN = 1'b0,
  parameter int unsigned CLK_SET = 1,
  parameter bit FILTER_EN = 1'b1,
  parameter int unsigned FILT_CYCLES = FILTER_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] input_pins,
  output logic input_irq_flag,
  output logic output_bit_zero,
  output logic output_bit_zero_oe_n,
  output logic output_bit_one,
  output logic output_bit_one_oe_n
);

  // ==========================================================
  // Build checks
  if (CLK_SET < 1 || CLK_SET > 5)
  begin : bad_set_g
    $error("kitop_port: CLK_SET must be 1 to 5");
  end
  if (OUT0_MODE == OUT0_INV_BUZZER && !OUT1_BUZZER)
  begin : bad_inv_g
    $error("kitop_port: inverse buzzer needs bit one as buzzer");
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic [3:0] en;
    logic flag;
    logic [3:0] clean_prev;
    logic [1:0] out_data;
    logic [1:0] rate_sel;
    logic tone_sel;
    logic divided_clock_output_gate;
    logic buz_gate0;
    logic buz_gate1;
    logic pin0;
    logic pin1;
    logic [DATA_W-1:0] rdata;
  } kitop_port_s;

  localparam kitop_port_s PORT_RST = '{
    en: EN_RST,
    flag: FLAG_RST,
    clean_prev: 4'h0,
    out_data: OUT_RST,
    rate_sel: RATE_RST,
    tone_sel: TONE_RST,
    divided_clock_output_gate: 1'b0,
    buz_gate0: 1'b0,
    buz_gate1: 1'b0,
    pin0: 1'b0,
    pin1: 1'b0,
    rdata: '0
  };

  kitop_port_s s_q;
  kitop_port_s s_d;

  logic [3:0] pin_level;
  logic [3:0] pin_clean;
  logic [PHASE_W-1:0] phase;
  logic [PHASE_W-1:0] phase_nx;
  logic setup;
  logic access;
  logic wr_acc;
  logic rd_flag_acc;
  logic set_evt;
  logic clr_evt;
  logic cwave;
  logic bwave;
  logic div_one;
  int unsigned clk_log2;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return a == reg_addr(IDX_PIN_LEVELS) || a == reg_addr(IDX_IRQ_ENABLES)
        || a == reg_addr(IDX_IRQ_FLAG) || a == reg_addr(IDX_OUT_DATA)
        || a == reg_addr(IDX_FREQ_CTRL);
  endfunction

  function automatic logic wave_of(input logic [PHASE_W-1:0] p, input int unsigned l);
    return (l == 0) ? 1'b0 : p[l-1];
  endfunction

  // ==========================================================
  // Input synchroniser and noise filter
  kitop_in_filter #(
    .WIDTH(4),
    .FILTER_EN(FILTER_EN),
    .FILT_CYCLES(FILT_CYCLES)
  ) u_filter (
    .pclk(pclk),
    .presetn(presetn),
    .pins(input_pins),
    .level(pin_level),
    .clean(pin_clean)
  );

  // ==========================================================
  // Shared divider for the clock output and the tones
  kitop_divider #(
    .WIDTH(PHASE_W)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .phase(phase)
  );

  assign phase_nx = phase + PHASE_W'(1);
  assign clk_log2 = rate_log2(CLK_SET, s_q.rate_sel);
  assign div_one = (clk_log2 == 0);
  assign cwave = wave_of(phase_nx, clk_log2);
  assign bwave = s_q.tone_sel ? phase_nx[TONE_2K_LOG2-1] : phase_nx[TONE_4K_LOG2-1];

  // ==========================================================
  // APB slave: zero wait states, data captured in the setup cycle
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr_acc = access && pwrite && is_mapped(paddr);
  assign rd_flag_acc = access && !pwrite && paddr == reg_addr(IDX_IRQ_FLAG);
  assign set_evt = |((pin_clean ^ s_q.clean_prev) & s_q.en);
  // Only a flag value that was actually returned is cleared
  assign clr_evt = rd_flag_acc && s_q.rdata[FLD_FLAG];

  always_comb
  begin
    s_d = s_q;
    s_d.clean_prev = pin_clean;
    s_d.flag = (s_q.flag && !clr_evt) || set_evt;

    if (setup)
    begin
      s_d.rdata = '0;
      unique case (1'b1)
        paddr == reg_addr(IDX_PIN_LEVELS): s_d.rdata[3:0] = pin_level;
        paddr == reg_addr(IDX_IRQ_ENABLES): s_d.rdata[3:0] = s_q.en;
        paddr == reg_addr(IDX_IRQ_FLAG): s_d.rdata[FLD_FLAG] = s_q.flag;
        paddr == reg_addr(IDX_OUT_DATA): s_d.rdata[1:0] = s_q.out_data;
        paddr == reg_addr(IDX_FREQ_CTRL):
        begin
          s_d.rdata[FLD_RATE_HI] = s_q.rate_sel[1];
          s_d.rdata[FLD_RATE_LO] = s_q.rate_sel[0];
          s_d.rdata[FLD_TONE] = s_q.tone_sel;
        end
        default: s_d.rdata = '0;
      endcase
    end

    // Level and flag registers take no writes
    if (wr_acc && paddr == reg_addr(IDX_IRQ_ENABLES))
      s_d.en = pwdata[3:0];
    if (wr_acc && paddr == reg_addr(IDX_OUT_DATA))
    begin
      s_d.out_data[0] = pwdata[FLD_OUT_ZERO];
      s_d.out_data[1] = pwdata[FLD_OUT_ONE];
    end
    if (wr_acc && paddr == reg_addr(IDX_FREQ_CTRL))
    begin
      s_d.rate_sel = {pwdata[FLD_RATE_HI], pwdata[FLD_RATE_LO]};
      s_d.tone_sel = pwdata[FLD_TONE];
    end

    // Except at divide-by-one, gates move only while their wave is inactive, so no pulse is cut short
    if (!cwave || div_one)
      s_d.divided_clock_output_gate = s_q.out_data[0];
    if (bwave)
      s_d.buz_gate0 = INV_BY_BIT1 ? s_q.out_data[1] : s_q.out_data[0];
    if (!bwave)
      s_d.buz_gate1 = s_q.out_data[1];

    unique case (OUT0_MODE)
      OUT0_PLAIN: s_d.pin0 = s_q.out_data[0];
      OUT0_CLOCK: s_d.pin0 = s_d.divided_clock_output_gate && cwave;
      OUT0_INV_BUZZER: s_d.pin0 = s_d.buz_gate0 && !bwave;
      default: s_d.pin0 = s_q.out_data[0];
    endcase
    if (OUT1_BUZZER)
      s_d.pin1 = s_d.buz_gate1 && bwave;
    else
      s_d.pin1 = s_q.out_data[1];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= PORT_RST;
    else
      s_q <= s_d;
  end

  // ==========================================================
  // Outputs
  assign prdata = s_q.rdata;
  assign pready = 1'b1;
  assign pslverr = access && !is_mapped(paddr);
  assign input_irq_flag = s_q.flag;

  // Divide-by-one passes the clock itself; its gating cannot be glitch free
  assign output_bit_zero = (OUT0_MODE == OUT0_CLOCK && div_one) ? (pclk && s_q.divided_clock_output_gate)
                                                                : s_q.pin0;
  assign output_bit_one = s_q.pin1;
  assign output_bit_zero_oe_n = OUT0_OPEN_DRAIN ? !output_bit_zero : 1'b0;
  assign output_bit_one_oe_n = OUT1_OPEN_DRAIN ? !output_bit_one : 1'b0;

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  flag_set_a: assert property (set_evt |=> s_q.flag)
    else $error("enabled input change did not set the flag");
  flag_clear_a: assert property (clr_evt && !set_evt |=> !s_q.flag)
    else $error("flag not cleared by read");
  flag_nowrite_a: assert property (access && pwrite && paddr == reg_addr(IDX_IRQ_FLAG)
      && !set_evt |=> s_q.flag == $past(s_q.flag))
    else $error("write changed the flag");
  en_write_a: assert property (wr_acc && paddr == reg_addr(IDX_IRQ_ENABLES)
      |=> s_q.en == $past(pwdata[3:0]))
    else $error("enable write not stored");
  level_read_a: assert property (setup && paddr == reg_addr(IDX_PIN_LEVELS)
      |=> prdata[3:0] == $past(pin_level) && prdata[31:4] == '0)
    else $error("level read wrong");
  flag_upper_a: assert property (setup && paddr == reg_addr(IDX_IRQ_FLAG)
      |=> prdata[31:1] == '0 && prdata[0] == $past(s_q.flag))
    else $error("flag read wrong");
  tone_write_a: assert property (wr_acc && paddr == reg_addr(IDX_FREQ_CTRL)
      |=> s_q.tone_sel == $past(pwdata[FLD_TONE]) && s_q.rate_sel == $past(pwdata[1:0]))
    else $error("frequency control write not stored");
  clk_off_a: assert property (OUT0_MODE == OUT0_CLOCK && !s_q.out_data[0] && !div_one
      && !s_q.divided_clock_output_gate |=> !s_q.pin0)
    else $error("clock pin not held low while off");
  buzz_pair_a: assert property (OUT0_MODE == OUT0_INV_BUZZER && s_q.buz_gate0
      && s_q.buz_gate1 && $past(s_q.buz_gate0) && $past(s_q.buz_gate1)
      |-> s_q.pin0 == !s_q.pin1)
    else $error("buzzer pair not complementary");
  // The tone select must stay put over the high half, else a mid-wave switch is legal
  tone_rate_a: assert property (OUT1_BUZZER && s_q.buz_gate1 && !s_q.tone_sel
      && $rose(s_q.pin1) ##1 (!s_q.tone_sel) [*3] |=> $fell(s_q.pin1))
    else $error("4 kHz tone half period wrong");

  flag_set_c: cover property (set_evt);
  flag_read_c: cover property (clr_evt ##1 !s_q.flag);
  clk_run_c: cover property ($rose(s_q.pin0) ##[1:300] $fell(s_q.pin0));
  buzz_on_c: cover property (s_q.buz_gate1 && $rose(s_q.pin1));

endmodule
`default_nettype wire

/* kitop_far_side.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Keys and piezo buzzer at the far side of the port
module kitop_far_side
(
  input wire logic [3:0] key_state,
  output logic [3:0] input_pins,
  input wire logic pin_zero,
  input wire logic pin_zero_oe_n,
  input wire logic pin_one,
  input wire logic pin_one_oe_n,
  output logic level_zero,
  output logic level_one
);
  // Keys hold a steady level; bounce is not modelled
  assign input_pins = key_state;
  // A released pin has no pull, so show the opposite of the last drive
  assign level_zero = pin_zero_oe_n ? ~pin_zero : pin_zero;
  assign level_one = pin_one_oe_n ? ~pin_one : pin_one;
endmodule
`default_nettype wire

/* test_key_input_and_tone_output_port.sv */
`timescale 1ns/1ns
`default_nettype none
module test_key_input_and_tone_output_port;
  import kitop_pkg::*;
  localparam logic [9:0] A_LEV = {IDX_PIN_LEVELS, 2'b00};
  localparam logic [9:0] A_EN = {IDX_IRQ_ENABLES, 2'b00};
  localparam logic [9:0] A_FLAG = {IDX_IRQ_FLAG, 2'b00};
  localparam logic [9:0] A_OUT = {IDX_OUT_DATA, 2'b00};
  localparam logic [9:0] A_FRQ = {IDX_FREQ_CTRL, 2'b00};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] key_state = 4'h0;
  logic [3:0] input_pins;
  logic input_irq_flag;
  logic out0, out0_oe_n, out1, out1_oe_n, level_zero, level_one;
  int num_errors = 0;
  int checked = 0;
  logic [31:0] rd;
  logic err;
  int p;

  always #50 pclk = ~pclk;

  kitop_port #(.OUT0_MODE(OUT0_CLOCK), .OUT1_BUZZER(1'b1), .FILT_CYCLES(8)) kitop_port_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .input_pins(input_pins), .input_irq_flag(input_irq_flag),
    .output_bit_zero(out0), .output_bit_zero_oe_n(out0_oe_n),
    .output_bit_one(out1), .output_bit_one_oe_n(out1_oe_n)
  );

  kitop_far_side kitop_far_side_inst (
    .key_state(key_state), .input_pins(input_pins),
    .pin_zero(out0), .pin_zero_oe_n(out0_oe_n), .pin_one(out1), .pin_one_oe_n(out1_oe_n),
    .level_zero(level_zero), .level_one(level_one)
  );

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; held until pready is seen high at a rising edge
  task automatic apb(input logic we, input logic [9:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= we;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_check(input logic [9:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // Cycles between two rising edges of a pin, sampled away from the clock edge
  task automatic period(input bit which, output int n);
    logic prev;
    logic cur;
    int k;
    n = 0;
    k = 0;
    prev = 1'b1;
    while (k < 2 && n < 2000)
    begin
      @(negedge pclk);
      cur = which ? level_one : level_zero;
      if (k == 1)
        n++;
      if (cur === 1'b1 && prev === 1'b0)
        k++;
      prev = cur;
    end
  endtask

  task automatic report_and_stop;
    if (num_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    #5000000;
    num_errors++;
    report_and_stop();
  end

  // ==========================================================
  // Tests
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_check(A_EN, 32'h0);
    rd_check(A_FLAG, 32'h0);
    rd_check(A_OUT, 32'h0);
    rd_check(A_FRQ, 32'h0);
    check({30'h0, out0_oe_n, out1_oe_n}, 32'h0);
    apb(1'b1, A_EN, 32'hffffffff);
    rd_check(A_EN, 32'hf);
    apb(1'b1, A_EN, 32'h0);
    rd_check(A_EN, 32'h0);
    apb(1'b0, 10'h004, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    // Masked change must leave the flag clear
    key_state <= 4'ha;
    repeat (30) @(posedge pclk);
    rd_check(A_LEV, 32'ha);
    apb(1'b1, A_LEV, 32'h5);
    rd_check(A_LEV, 32'ha);
    rd_check(A_FLAG, 32'h0);
    apb(1'b1, A_EN, 32'h1);
    key_state <= 4'h8;
    repeat (30) @(posedge pclk);
    rd_check(A_FLAG, 32'h0);
    key_state <= 4'h9;
    repeat (30) @(posedge pclk);
    check({31'h0, input_irq_flag}, 32'h1);
    apb(1'b1, A_FLAG, 32'h0);
    rd_check(A_FLAG, 32'h1);
    rd_check(A_FLAG, 32'h0);
    key_state <= 4'h8;
    repeat (30) @(posedge pclk);
    rd_check(A_FLAG, 32'h1);
    // Clock output stays low while its gate bit is clear
    p = 0;
    repeat (300)
    begin
      @(negedge pclk);
      if (level_zero !== 1'b0)
        p++;
    end
    check(32'(p), 32'h0);
    apb(1'b1, A_OUT, 32'h3);
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b1, A_FRQ, 32'(c));
      rd_check(A_FRQ, 32'(c));
      period(1'b0, p);
      check(32'(p), 32'(1 << (7 - c)));
    end
    period(1'b1, p);
    check(32'(p), 32'h8);
    apb(1'b1, A_FRQ, 32'h8);
    rd_check(A_FRQ, 32'h8);
    period(1'b1, p);
    check(32'(p), 32'h10);
    apb(1'b1, A_OUT, 32'h0);
    // The clock gate waits for the slowest wave's high half to finish
    repeat (200) @(posedge pclk);
    @(negedge pclk);
    check({30'h0, level_one, level_zero}, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
